// file: rtl/atsr_flag.sv
// Sticky event flag; a set in the same cycle as a clear wins
module atsr_flag (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic set,
  input  wire logic clear,
  output logic      flag
);
  // Set has priority so an event landing on the clear cycle is kept
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule : atsr_flag

// file: rtl/atsr_pkg.sv
package atsr_pkg;
  // Query opcodes
  localparam logic [7:0]  OPC_TUNE_STATUS = 8'h42;
  localparam logic [7:0]  OPC_SIG_QUALITY = 8'h43;
  // Argument bit positions
  localparam int          ARG_ACK_BIT     = 0;
  localparam int          ARG_CANCEL_BIT  = 1;
  // Status byte bit positions
  localparam int          ST_CTS_BIT      = 7;
  localparam int          ST_ERR_BIT      = 6;
  localparam int          ST_SQ_BIT       = 3;
  localparam int          ST_STD_BIT      = 0;
  // Tune-status byte 1 positions
  localparam int          TS_EDGE_BIT     = 7;
  localparam int          TS_AFC_BIT      = 1;
  localparam int          TS_VALID_BIT    = 0;
  // Signal-quality byte 1 and 2 positions
  localparam int          SQ_SNRH_BIT     = 3;
  localparam int          SQ_SNRL_BIT     = 2;
  localparam int          SQ_STRH_BIT     = 1;
  localparam int          SQ_STRL_BIT     = 0;
  localparam int          SQ_MUTE_BIT     = 3;
  localparam int          SQ_AFC_BIT      = 1;
  localparam int          SQ_VALID_BIT    = 0;
  // Index of the last byte of each answer, status byte being index 0
  localparam logic [2:0]  TS_LAST_IDX     = 3'h7;
  localparam logic [2:0]  SQ_LAST_IDX     = 3'h5;
  // Highest antenna capacitor code
  localparam logic [15:0] CAP_CODE_MAX    = 16'h17ff;
  // Reset values
  localparam logic [7:0]  BYTE_RESET      = 8'h00;
  localparam logic [15:0] WORD_RESET      = 16'h0000;

  // Command sequencer states
  typedef enum logic [2:0] {
    ATSR_IDLE = 3'b001,
    ATSR_ARG  = 3'b010,
    ATSR_RESP = 3'b100
  } atsr_state_t;
endpackage : atsr_pkg

// file: rtl/atsr_top.sv
// Contract
// - Tune-status query is 0x42, one argument, status plus seven answer bytes.
// - Tune-status argument bit 1 aborts a seek in progress.
// - Tune-status argument bit 0 clears the seek/tune-complete indicator.
// - Clear-to-send is set, with optional interrupt, when next command is safe.
// - Byte 1 bit 7 reports seek hit band edge or returned to start.
// - Byte 1 bit 1 reports frequency control at its rail.
// - Byte 1 bit 0 reports the current channel is valid.
// - Bytes 2 and 3 carry tuned frequency in kHz, high byte first.
// - Bytes 4 and 5 carry strength and SNR measured at tune completion.
// - Bytes 6 and 7 carry antenna capacitor code, high first, 0 to 6143.
// - Signal-quality query is 0x43, one argument, status plus five bytes.
// - Quality argument bit 0 clears quality interrupt and four threshold flags.
// - Quality byte 1 bit 3 SNR above high, bit 2 SNR below low.
// - Quality byte 1 bit 1 strength above high, bit 0 below low.
// - Quality byte 2 bit 3 shows soft mute engaged.
// - Quality byte 2 bit 1 rail condition, bit 0 valid channel.
// - Quality bytes 4 and 5 hold present strength and SNR.
// - Wrap option one wraps at band edge, zero halts there.
// - Status byte complete flags update only on interrupt refresh command.
module atsr_top (
  input  wire logic               clk,
  input  wire logic               reset_n,
  // Command byte stream from the serial control interface
  input  wire logic               cmd_valid,
  input  wire logic [7:0]         cmd_data,
  output logic                    cmd_ready,
  // Answer byte stream toward the serial control interface
  output logic                    rsp_valid,
  output logic [7:0]              rsp_data,
  input  wire logic               rsp_ready,
  // Mode and interrupt configuration
  input  wire logic               powered_up,
  input  wire logic               cts_irq_enable,
  input  wire logic               interrupt_refresh_cmd,
  output logic                    cts_irq,
  output logic                    cts,
  output logic                    err,
  // Seek and tune engine
  input  wire logic               seek_busy,
  input  wire logic               seek_wrap,
  input  wire logic               seek_hit_edge,
  input  wire logic               seek_back_at_start,
  input  wire logic               tune_done,
  output logic                    seek_cancel,
  output logic                    seek_tune_done_flag,
  // Receiver measurements
  input  wire logic               afc_rail_flag,
  input  wire logic               valid_channel,
  input  wire logic               soft_mute_active,
  input  wire logic [15:0]        tuned_freq_value,
  input  wire logic [15:0]        antenna_cap_code,
  input  wire logic [7:0]         rssi_now,
  input  wire logic [7:0]         snr_now,
  // Threshold crossing events, one cycle each
  input  wire logic               snr_high_cross_evt,
  input  wire logic               snr_low_cross_evt,
  input  wire logic               strength_high_cross_evt,
  input  wire logic               strength_low_cross_evt,
  output logic                    signal_quality_flag
);
  import atsr_pkg::*;

  atsr_state_t       state;
  atsr_state_t       next_state;
  logic [7:0]        opcode;
  logic [2:0]        idx;
  logic [2:0]        last_idx;
  logic              band_edge_flag;
  logic [7:0]        tune_rssi;
  logic [7:0]        tune_snr;
  logic [7:0]        snap_b1;
  logic [15:0]       snap_word1;
  logic [15:0]       snap_word2;
  logic [7:0]        snap_b4;
  logic [7:0]        snap_b5;
  logic              stc_pending;
  logic              sq_pending;
  logic              snr_high_cross;
  logic              snr_low_cross;
  logic              strength_high_cross;
  logic              strength_low_cross;

  // Byte acceptance and argument decode
  wire               take_cmd    = cmd_valid && (state == ATSR_IDLE);
  wire               take_arg    = cmd_valid && (state == ATSR_ARG);
  wire               is_tune_op  = (opcode == OPC_TUNE_STATUS);
  wire               known_op    = (cmd_data == OPC_TUNE_STATUS) || (cmd_data == OPC_SIG_QUALITY);
  wire               op_ok       = known_op && powered_up;
  wire               ack_bit     = cmd_data[ARG_ACK_BIT];
  wire               tune_ack    = take_arg && is_tune_op && ack_bit;
  wire               sq_ack      = take_arg && !is_tune_op && ack_bit;
  wire               cancel_req  = take_arg && is_tune_op && cmd_data[ARG_CANCEL_BIT];
  wire               advance     = (state == ATSR_RESP) && rsp_ready;
  wire               last_byte   = (idx == last_idx);
  wire [2:0]         idx_inc     = idx + 3'h1;
  wire               any_cross   = snr_high_cross_evt || snr_low_cross_evt
                                   || strength_high_cross_evt || strength_low_cross_evt;

  // Seek outcome picks its edge event by the wrap option
  wire               edge_event  = seek_wrap ? seek_back_at_start : seek_hit_edge;
  // Keep the capacitor code inside its legal span
  wire [15:0]        cap_clamped = (antenna_cap_code > CAP_CODE_MAX) ? CAP_CODE_MAX
                                   : antenna_cap_code;

  // Status byte as the host sees it
  wire [7:0]         status_byte = {1'b1, err, 2'b00, signal_quality_flag, 2'b00,
                                    seek_tune_done_flag};

  // Answer byte bodies, built from the current measurements
  wire [7:0]         tune_b1     = {band_edge_flag, 5'b00000, afc_rail_flag, valid_channel};
  wire [7:0]         sq_b1       = {4'h0, snr_high_cross, snr_low_cross,
                                    strength_high_cross, strength_low_cross};
  wire [7:0]         sq_b2       = {4'h0, soft_mute_active, 1'b0, afc_rail_flag, valid_channel};

  // Byte selected by the answer index
  wire [7:0]         next_byte   = (idx_inc == 3'h1) ? snap_b1 :
                                   (idx_inc == 3'h2) ? snap_word1[15:8] :
                                   (idx_inc == 3'h3) ? snap_word1[7:0] :
                                   (idx_inc == 3'h4) ? snap_b4 :
                                   (idx_inc == 3'h5) ? snap_b5 :
                                   (idx_inc == 3'h6) ? snap_word2[15:8] :
                                   snap_word2[7:0];

  // Sequencer: opcode, argument, then answer bytes
  always_comb begin
    next_state = state;
    unique case (state)
      ATSR_IDLE: begin
        if (take_cmd && op_ok) begin
          next_state = ATSR_ARG;
        end
      end
      ATSR_ARG: begin
        if (take_arg) begin
          next_state = ATSR_RESP;
        end
      end
      ATSR_RESP: begin
        if (advance && last_byte) begin
          next_state = ATSR_IDLE;
        end
      end
      default: begin
        next_state = ATSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ATSR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Opcode and answer length
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      opcode   <= BYTE_RESET;
      last_idx <= 3'h0;
    end else if (take_cmd && op_ok) begin
      opcode   <= cmd_data;
      last_idx <= (cmd_data == OPC_TUNE_STATUS) ? TS_LAST_IDX : SQ_LAST_IDX;
    end
  end

  // Error bit: an unknown opcode or a query outside power-up mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err <= 1'b0;
    end else if (take_cmd) begin
      err <= !op_ok;
    end
  end

  // Flow control; the host waits for clear-to-send before the next opcode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_ready <= 1'b1;
      cts       <= 1'b1;
      cts_irq   <= 1'b0;
    end else begin
      cmd_ready <= (next_state == ATSR_IDLE) || (next_state == ATSR_ARG);
      cts       <= (next_state == ATSR_IDLE);
      cts_irq   <= cts_irq_enable && (next_state == ATSR_IDLE)
                   && (state != ATSR_IDLE);
    end
  end

  // Seek result and measurements frozen when tuning completes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      band_edge_flag <= 1'b0;
      tune_rssi      <= BYTE_RESET;
      tune_snr       <= BYTE_RESET;
    end else if (tune_done) begin
      band_edge_flag <= edge_event;
      tune_rssi      <= rssi_now;
      tune_snr       <= snr_now;
    end
  end

  // Answer snapshot taken with the argument, before any acknowledge lands
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      snap_b1    <= BYTE_RESET;
      snap_word1 <= WORD_RESET;
      snap_word2 <= WORD_RESET;
      snap_b4    <= BYTE_RESET;
      snap_b5    <= BYTE_RESET;
    end else if (take_arg) begin
      snap_b1    <= is_tune_op ? tune_b1 : sq_b1;
      snap_word1 <= is_tune_op ? tuned_freq_value : {sq_b2, 8'h00};
      snap_word2 <= cap_clamped;
      snap_b4    <= is_tune_op ? tune_rssi : rssi_now;
      snap_b5    <= is_tune_op ? tune_snr : snr_now;
    end
  end

  // Answer stream; byte 2 of the quality answer is the high half of word1
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idx       <= 3'h0;
      rsp_valid <= 1'b0;
      rsp_data  <= BYTE_RESET;
    end else if (take_arg) begin
      idx       <= 3'h0;
      rsp_valid <= 1'b1;
      rsp_data  <= status_byte;
    end else if (advance) begin
      idx       <= idx_inc;
      rsp_valid <= !last_byte;
      rsp_data  <= last_byte ? BYTE_RESET
                   : ((idx_inc == 3'h3) && !is_tune_op) ? 8'h00 : next_byte;
    end
  end

  // Cancel only reaches the engine while a seek is running
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seek_cancel <= 1'b0;
    end else begin
      seek_cancel <= cancel_req && seek_busy;
    end
  end

  // Pending event flags, visible to the host only after a refresh
  atsr_flag u_stc_pending (
    .clk     (clk),
    .reset_n (reset_n),
    .set     (tune_done),
    .clear   (tune_ack),
    .flag    (stc_pending)
  );

  atsr_flag u_sq_pending (
    .clk     (clk),
    .reset_n (reset_n),
    .set     (any_cross),
    .clear   (sq_ack),
    .flag    (sq_pending)
  );

  // Threshold crossing flags, all cleared by one acknowledge
  atsr_flag u_snr_high (
    .clk     (clk),
    .reset_n (reset_n),
    .set     (snr_high_cross_evt),
    .clear   (sq_ack),
    .flag    (snr_high_cross)
  );

  atsr_flag u_snr_low (
    .clk     (clk),
    .reset_n (reset_n),
    .set     (snr_low_cross_evt),
    .clear   (sq_ack),
    .flag    (snr_low_cross)
  );

  atsr_flag u_str_high (
    .clk     (clk),
    .reset_n (reset_n),
    .set     (strength_high_cross_evt),
    .clear   (sq_ack),
    .flag    (strength_high_cross)
  );

  atsr_flag u_str_low (
    .clk     (clk),
    .reset_n (reset_n),
    .set     (strength_low_cross_evt),
    .clear   (sq_ack),
    .flag    (strength_low_cross)
  );

  // Status byte copies follow the pending flags only on refresh
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seek_tune_done_flag <= 1'b0;
      signal_quality_flag <= 1'b0;
    end else if (interrupt_refresh_cmd) begin
      seek_tune_done_flag <= stc_pending;
      signal_quality_flag <= sq_pending;
    end
  end
endmodule : atsr_top

// file: verif/am_tune_signal_status_reporter_bench.sv
module am_tune_signal_status_reporter_bench;
  import atsr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, reset_n, cmd_valid, cmd_ready, rsp_valid, rsp_ready, powered_up, go;
  logic        cts_irq_enable, interrupt_refresh_cmd, cts_irq, cts, err, seek_busy, slow;
  logic        seek_wrap, seek_hit_edge, seek_back_at_start, tune_done, seek_cancel, done;
  logic        seek_tune_done_flag, afc_rail_flag, valid_channel, soft_mute_active;
  logic        snr_high_cross_evt, snr_low_cross_evt, strength_high_cross_evt;
  logic        strength_low_cross_evt, signal_quality_flag;
  logic [7:0]  cmd_data, rsp_data, rssi_now, snr_now, opc, arg;
  logic [15:0] tuned_freq_value, antenna_cap_code;
  logic [3:0]  nb;
  logic [63:0] got;
  int          n_fail, n_tests, n_cancel, n_irq, k;
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, a, e); end end
  atsr_top dut (.*);
  atsr_host host (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Count one-cycle pulses the block emits
  always @(posedge clk) begin
    if (seek_cancel === 1'b1) n_cancel++;
    if (cts_irq === 1'b1) n_irq++;
  end
  task automatic give_verdict;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  // One query through the host; a hung host ends the run
  task automatic q(input logic [7:0] o, input logic [7:0] a, input logic [3:0] n, input logic s);
    int w;
    @(posedge clk);
    {opc, arg, nb, slow, go} <= {o, a, n, s, 1'b1};
    @(posedge clk);
    go <= 1'b0;
    for (w = 0; done !== 1'b1 && w < 300; w++) @(posedge clk);
    if (w >= 300) begin
      n_fail++;
      give_verdict();
    end
  endtask : q
  task automatic refresh;
    @(posedge clk) interrupt_refresh_cmd <= 1'b1;
    @(posedge clk) interrupt_refresh_cmd <= 1'b0;
    @(posedge clk);
  endtask : refresh
  task automatic t_tune;
    @(posedge clk);
    {seek_hit_edge, afc_rail_flag, valid_channel, tune_done} <= 4'hf;
    {tuned_freq_value, antenna_cap_code} <= 32'h06a4_17ff;
    {rssi_now, snr_now} <= 16'h2a13;
    // Later readings must not leak into the snapshot taken at completion
    @(posedge clk) {tune_done, rssi_now, snr_now} <= 17'h0_5566;
    q(OPC_TUNE_STATUS, 8'h00, 4'h8, 1'b0);
    `CHK(got, 64'h8083_06a4_2a13_17ff)
    $display("t_tune end");
  endtask : t_tune
  task automatic t_ack;
    @(posedge clk);
    {seek_wrap, seek_hit_edge, seek_back_at_start, afc_rail_flag, valid_channel} <= 5'h18;
    {antenna_cap_code, tune_done} <= 17'h1_ffff;
    @(posedge clk) tune_done <= 1'b0;
    refresh();
    `CHK(seek_tune_done_flag, 1'b1)
    q(OPC_TUNE_STATUS, 8'h01, 4'h8, 1'b1);
    `CHK(got, 64'h8100_06a4_5566_17ff)
    refresh();
    `CHK(seek_tune_done_flag, 1'b0)
    $display("t_ack end");
  endtask : t_ack
  task automatic t_cancel;
    @(posedge clk) seek_busy <= 1'b1;
    q(OPC_TUNE_STATUS, 8'h02, 4'h8, 1'b0);
    `CHK(n_cancel, 1)
    // Wrapped seek back at its start reports the band edge; the ack drops the new completion
    @(posedge clk) {seek_busy, seek_back_at_start, tune_done} <= 3'h3;
    @(posedge clk) tune_done <= 1'b0;
    q(OPC_TUNE_STATUS, 8'h03, 4'h8, 1'b0);
    `CHK(n_cancel, 1)
    `CHK(got, 64'h8080_06a4_5566_17ff)
    $display("t_cancel end");
  endtask : t_cancel
  task automatic t_quality;
    @(posedge clk);
    {soft_mute_active, afc_rail_flag, valid_channel, rssi_now, snr_now} <= 19'h6_3307;
    {snr_high_cross_evt, strength_low_cross_evt} <= 2'h3;
    @(posedge clk) {snr_high_cross_evt, strength_low_cross_evt} <= 2'h0;
    q(OPC_SIG_QUALITY, 8'h00, 4'h6, 1'b1);
    `CHK(got[47:0], 48'h8009_0a00_3307)
    refresh();
    `CHK(signal_quality_flag, 1'b1)
    q(OPC_SIG_QUALITY, 8'h01, 4'h6, 1'b0);
    `CHK(got[47:32], 16'h8809)
    q(OPC_SIG_QUALITY, 8'h00, 4'h6, 1'b0);
    `CHK(got[39:32], 8'h00)
    refresh();
    `CHK(signal_quality_flag, 1'b0)
    $display("t_quality end");
  endtask : t_quality
  task automatic t_refuse;
    q(8'h41, 8'h00, 4'h0, 1'b0);
    `CHK({err, cts}, 2'h3)
    @(posedge clk) powered_up <= 1'b0;
    q(OPC_TUNE_STATUS, 8'h00, 4'h0, 1'b0);
    `CHK({err, cts}, 2'h3)
    @(posedge clk) powered_up <= 1'b1;
    k = n_irq;
    q(OPC_SIG_QUALITY, 8'h00, 4'h6, 1'b0);
    `CHK(got[47:40], 8'h80)
    // The pulse counter updates on the edge after the pulse
    @(posedge clk);
    `CHK({n_irq == k + 1, cts}, 2'h3)
    // With the interrupt disabled, a finished answer raises no pulse
    @(posedge clk) cts_irq_enable <= 1'b0;
    q(OPC_TUNE_STATUS, 8'h00, 4'h8, 1'b0);
    @(posedge clk);
    `CHK(n_irq, k + 1)
    $display("t_refuse end");
  endtask : t_refuse
  initial begin
    {go, slow, nb, opc, arg, seek_busy, seek_wrap, seek_hit_edge, seek_back_at_start} = '0;
    {tune_done, afc_rail_flag, valid_channel, soft_mute_active, interrupt_refresh_cmd} = '0;
    {snr_high_cross_evt, snr_low_cross_evt, strength_high_cross_evt} = '0;
    {strength_low_cross_evt, rssi_now, snr_now, tuned_freq_value, antenna_cap_code} = '0;
    {powered_up, cts_irq_enable, reset_n} = 3'h6;
    {n_fail, n_tests, n_cancel, n_irq} = '0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_tune();
    t_ack();
    t_cancel();
    t_quality();
    t_refuse();
    give_verdict();
  end
endmodule : am_tune_signal_status_reporter_bench

// file: verif/atsr_host.sv
module atsr_host (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [7:0]  opc,
  input  wire logic [7:0]  arg,
  input  wire logic [3:0]  nb,
  input  wire logic        slow,
  input  wire logic        cmd_ready,
  input  wire logic        rsp_valid,
  input  wire logic [7:0]  rsp_data,
  output logic             cmd_valid,
  output logic [7:0]       cmd_data,
  output logic             rsp_ready,
  output logic             done,
  output logic [63:0]      got
);
  timeunit 1ns;
  timeprecision 1ns;
  int k;
  // Host side: opcode, argument, then drains nb bytes; slow stalls every other cycle
  initial begin
    {cmd_valid, cmd_data, rsp_ready, done, got} = '0;
    forever begin
      @(posedge clk);
      done <= 1'b0;
      if (go) begin
        got <= 64'h0;
        cmd_valid <= 1'b1;
        cmd_data <= opc;
        k = 0;
        do begin
          @(posedge clk);
          k++;
        end while (!cmd_ready && k < 50);
        if (nb != 4'h0) begin
          cmd_data <= arg;
          k = 0;
          do begin
            @(posedge clk);
            k++;
          end while (!cmd_ready && k < 50);
        end
        cmd_valid <= 1'b0;
        cmd_data <= ~cmd_data;
        rsp_ready <= ~slow && (nb != 4'h0);
        k = 0;
        for (int g = 0; g < 100 && k < nb; g++) begin
          @(posedge clk);
          if (rsp_valid && rsp_ready) begin
            got <= {got[55:0], rsp_data};
            k++;
          end
          // Ready drops on the edge that takes the last byte, so it is set once per step
          rsp_ready <= (k < nb) && (!slow || !rsp_ready);
        end
        done <= 1'b1;
      end
    end
  end
endmodule : atsr_host

// file: verif/atsr_top_asserts.sv
module atsr_top_asserts (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire logic       cmd_ready,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic       rsp_ready,
  input wire logic       powered_up,
  input wire logic       interrupt_refresh_cmd,
  input wire logic       cts_irq,
  input wire logic       cts,
  input wire logic       err,
  input wire logic       seek_busy,
  input wire logic       seek_cancel,
  input wire logic       seek_tune_done_flag,
  input wire logic       signal_quality_flag
);
  import atsr_pkg::*;
  logic [7:0] opc_q;
  logic [3:0] n_out;
  logic       legal;
  // Opcode the receiver would accept right now
  assign legal = powered_up && (cmd_data == OPC_TUNE_STATUS || cmd_data == OPC_SIG_QUALITY);
  // Opcode of the answer in flight and bytes consumed so far
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      opc_q <= 8'h00;
      n_out <= 4'h0;
    end else begin
      if (cmd_valid && cts && legal) opc_q <= cmd_data;
      n_out <= rsp_valid ? n_out + {3'h0, rsp_ready} : 4'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_op;
    cmd_valid && cts && legal;
  endsequence
  sequence s_arg;
    cmd_valid && cmd_ready && !cts;
  endsequence
  // Status byte mirrors the live status bits
  sequence s_status;
    rsp_valid && !cmd_ready && !cts &&
      rsp_data == {1'b1, err, 2'b00, signal_quality_flag, 2'b00, seek_tune_done_flag};
  endsequence
  a_op_to_arg: assert property (s_op |=> !cts && cmd_ready && !err)
    else $error("legal opcode did not open the argument phase");
  a_refused_op: assert property (cmd_valid && cts && !legal |=> cts && err)
    else $error("refused opcode not flagged");
  a_status_first: assert property (s_arg |=> s_status)
    else $error("status byte wrong after argument");
  a_byte_stands: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("answer byte moved while stalled");
  a_answer_len: assert property ($fell(rsp_valid) |->
    n_out == ((opc_q == OPC_TUNE_STATUS) ? 4'h8 : 4'h6)) else $error("answer length wrong");
  a_idle_ready: assert property (cts |-> cmd_ready && !rsp_valid)
    else $error("idle without command ready");
  a_irq_pulse: assert property (cts_irq |-> $rose(cts) ##1 !cts_irq)
    else $error("ready interrupt not a single pulse on return to idle");
  a_cancel_pulse: assert property (seek_cancel |-> $past(seek_busy) && rsp_valid ##1 !seek_cancel)
    else $error("seek cancel pulse out of place");
  a_flag_refresh: assert property ($changed(seek_tune_done_flag) ||
    $changed(signal_quality_flag) |-> $past(interrupt_refresh_cmd)) else $error("flag moved alone");
endmodule : atsr_top_asserts
bind atsr_top atsr_top_asserts chk (.*);
